// ===== hdl/modem_ctrl_pkg.sv
package modem_ctrl_pkg;

   // Word indices of the register map; byte address is four times these
   localparam logic [2:0] IDX_MODEM_CONTROL  = 3'h0;
   localparam logic [2:0] IDX_MODEM_STATUS   = 3'h1;
   localparam logic [2:0] IDX_LINE_CONTROL   = 3'h2;
   localparam logic [2:0] IDX_INT_ENABLE     = 3'h3;
   localparam logic [2:0] IDX_LINE_STATUS    = 3'h4;
   localparam logic [2:0] IDX_DIVISOR_LOW    = 3'h5;
   localparam logic [2:0] IDX_DIVISOR_HIGH   = 3'h6;

   // Field positions in modem_control
   localparam int MC_TERMINAL_READY = 0;
   localparam int MC_REQUEST_SEND   = 1;
   localparam int MC_USER_OUT       = 2;
   localparam int MC_INT_GATE       = 3;
   localparam int MC_LOOPBACK       = 4;

   // Field positions in line_control and interrupt_enable_reg
   localparam int LC_BREAK          = 6;
   localparam int LC_DIVISOR_ACCESS = 7;
   localparam int IE_RX_DATA        = 0;
   localparam int IE_TX_EMPTY       = 1;
   localparam int IE_LINE_STATUS    = 2;
   localparam int IE_MODEM_STATUS   = 3;

   // Values after reset
   localparam logic [4:0]  MODEM_CONTROL_RESET = 5'h00;
   localparam logic [7:0]  LINE_CONTROL_RESET  = 8'h00;
   localparam logic [3:0]  INT_ENABLE_RESET    = 4'h0;
   localparam logic [15:0] DIVISOR_RESET       = 16'h0001;

   // Avalon-MM request from the master
   typedef struct packed {
      logic       read;
      logic       write;
      logic [4:0] address;
      logic [7:0] writedata;
   } avmm_req_t;

   // Modem status inputs as they arrive on the pins, active low
   typedef struct packed {
      logic line_detect_n;
      logic ring_n;
      logic set_ready_n;
      logic clear_to_send_n;
   } modem_in_t;

   // Receiver error pulses, one cycle each
   typedef struct packed {
      logic break_seen;
      logic framing;
      logic parity;
      logic overrun;
   } rx_err_t;

endpackage : modem_ctrl_pkg

// ===== hdl/modem_ctrl.sv
module modem_ctrl (
   input  wire logic                    sys_clk,
   input  wire logic                    rst_n,
   input  wire modem_ctrl_pkg::avmm_req_t bus_req,
   output logic                         waitrequest,
   output logic [7:0]                   readdata,
   input  wire modem_ctrl_pkg::modem_in_t modem_in,
   output logic                         terminal_ready_n,
   output logic                         request_send_n,
   input  wire logic                    serial_in,
   output logic                         serial_out,
   input  wire logic                    tx_shift_out,
   output logic                         rx_shift_in,
   input  wire modem_ctrl_pkg::rx_err_t rx_err,
   input  wire logic                    rx_data_ready,
   input  wire logic                    tx_holding_empty,
   input  wire logic                    tx_all_empty,
   output logic                         baud_tick,
   output logic                         irq_out
);

   // Register state
   logic [4:0]  modem_control_q;
   logic [7:0]  line_control_q;
   logic [3:0]  int_enable_q;
   logic [3:0]  line_err_q;
   logic [3:0]  changed_q;
   logic [3:0]  level_prev_q;
   logic [15:0] divisor_q;
   logic [15:0] baud_count_q;
   logic [3:0]  modem_meta_q;
   logic [3:0]  modem_sync_q;
   logic        sin_meta_q;
   logic        sin_sync_q;
   logic        wait_q;
   logic [7:0]  rdata_q;

   // Bus decode; access lands on the edge where waitrequest is low
   wire         access    = (bus_req.read | bus_req.write) & ~wait_q;
   wire         wr_acc    = access & bus_req.write;
   wire         rd_acc    = access & bus_req.read;
   wire [2:0]   idx       = bus_req.address[4:2];
   wire         aligned   = (bus_req.address[1:0] == 2'h0);
   wire         dl_open   = line_control_q[modem_ctrl_pkg::LC_DIVISOR_ACCESS];
   wire         loopback  = modem_control_q[modem_ctrl_pkg::MC_LOOPBACK];

   function automatic logic hit(input logic [2:0] i, input logic [2:0] want,
                                input logic ok);
      hit = ok & (i == want);
   endfunction : hit

   wire sel_mc  = hit(idx, modem_ctrl_pkg::IDX_MODEM_CONTROL, aligned);
   wire sel_ms  = hit(idx, modem_ctrl_pkg::IDX_MODEM_STATUS, aligned);
   wire sel_lc  = hit(idx, modem_ctrl_pkg::IDX_LINE_CONTROL, aligned);
   wire sel_ie  = hit(idx, modem_ctrl_pkg::IDX_INT_ENABLE, aligned);
   wire sel_ls  = hit(idx, modem_ctrl_pkg::IDX_LINE_STATUS, aligned);
   // Divisor latches vanish from the map while the access bit is clear
   wire sel_dll = hit(idx, modem_ctrl_pkg::IDX_DIVISOR_LOW, aligned)
                  & dl_open;
   wire sel_dlh = hit(idx, modem_ctrl_pkg::IDX_DIVISOR_HIGH, aligned)
                  & dl_open;

   // Status level source: pins normally, control bits in loopback
   // Order is {detect, ring, ready, clear} = status bits 7..4
   wire [3:0] pin_level  = ~modem_sync_q;
   wire [3:0] loop_level = {modem_control_q[modem_ctrl_pkg::MC_INT_GATE],
                            modem_control_q[modem_ctrl_pkg::MC_USER_OUT],
                            modem_control_q[modem_ctrl_pkg::MC_TERMINAL_READY],
                            modem_control_q[modem_ctrl_pkg::MC_REQUEST_SEND]};
   wire [3:0] level      = loopback ? loop_level : pin_level;

   // Change detection against the previous sample
   wire [3:0] toggled    = level ^ level_prev_q;
   wire [3:0] change_now = {toggled[3],
                            level_prev_q[2] & ~level[2],
                            toggled[1],
                            toggled[0]};

   // A read clears only what it returned; fresh events survive
   wire [3:0] ms_cleared = (rd_acc & sel_ms) ? rdata_q[3:0] : 4'h0;
   wire [3:0] changed_d  = (changed_q & ~ms_cleared) | change_now;
   wire [3:0] ls_cleared = (rd_acc & sel_ls) ? rdata_q[4:1] : 4'h0;
   wire [3:0] line_err_d = (line_err_q & ~ls_cleared) | rx_err;

   wire [7:0] modem_status = {level, changed_q};
   wire [7:0] line_status  = {1'b0, tx_all_empty, tx_holding_empty,
                              line_err_q, rx_data_ready};

   // Read mux, sampled one cycle before the access edge
   wire [7:0] rdata_d =
      sel_mc  ? {3'h0, modem_control_q} :
      sel_ms  ? modem_status :
      sel_lc  ? line_control_q :
      sel_ie  ? {4'h0, int_enable_q} :
      sel_ls  ? line_status :
      sel_dll ? divisor_q[7:0] :
      sel_dlh ? divisor_q[15:8] : 8'h00;

   // Interrupt sources and gate
   wire src_line  = int_enable_q[modem_ctrl_pkg::IE_LINE_STATUS]
                    & (|line_err_q);
   wire src_rx    = int_enable_q[modem_ctrl_pkg::IE_RX_DATA] & rx_data_ready;
   wire src_tx    = int_enable_q[modem_ctrl_pkg::IE_TX_EMPTY]
                    & tx_holding_empty;
   wire src_modem = int_enable_q[modem_ctrl_pkg::IE_MODEM_STATUS]
                    & (|changed_q);
   wire irq_d     = modem_control_q[modem_ctrl_pkg::MC_INT_GATE]
                    & (src_line | src_rx | src_tx | src_modem);

   // Divisor writes and baud counter
   wire        div_wr      = wr_acc & (sel_dll | sel_dlh);
   wire [15:0] divisor_d   = {sel_dlh & wr_acc ? bus_req.writedata
                                               : divisor_q[15:8],
                              sel_dll & wr_acc ? bus_req.writedata
                                               : divisor_q[7:0]};
   // A zero divisor parks the generator rather than wrapping forever
   wire        count_end   = (baud_count_q == 16'h0001);
   wire        tick_d      = count_end & ~div_wr;
   wire [15:0] baud_count_d =
      div_wr    ? divisor_d :
      count_end ? divisor_q :
      (baud_count_q == 16'h0000) ? 16'h0000 :
      baud_count_q - 16'h0001;

   // Pin outputs; loopback forces the pins idle and feeds tx_shift_out to rx_shift_in
   wire tr_n_d = loopback
               | ~modem_control_q[modem_ctrl_pkg::MC_TERMINAL_READY];
   wire rs_n_d = loopback
               | ~modem_control_q[modem_ctrl_pkg::MC_REQUEST_SEND];
   wire serial_out_d = loopback | (~line_control_q[modem_ctrl_pkg::LC_BREAK]
                             & tx_shift_out);
   wire rxin_d = loopback ? tx_shift_out : sin_sync_q;

   // Two-stage synchronisers for all pin inputs
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         modem_meta_q <= 4'hF;
         modem_sync_q <= 4'hF;
         sin_meta_q   <= 1'b1;
         sin_sync_q   <= 1'b1;
      end else begin
         modem_meta_q <= modem_in;
         modem_sync_q <= modem_meta_q;
         sin_meta_q   <= serial_in;
         sin_sync_q   <= sin_meta_q;
      end
   end

   // Bus handshake: one wait cycle, then a single low cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_q  <= 1'b1;
         rdata_q <= 8'h00;
      end else begin
         wait_q  <= ~(wait_q & (bus_req.read | bus_req.write));
         rdata_q <= rdata_d;
      end
   end

   // Software-written registers; line status writes are ignored
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         modem_control_q <= modem_ctrl_pkg::MODEM_CONTROL_RESET;
         line_control_q  <= modem_ctrl_pkg::LINE_CONTROL_RESET;
         int_enable_q    <= modem_ctrl_pkg::INT_ENABLE_RESET;
         divisor_q       <= modem_ctrl_pkg::DIVISOR_RESET;
      end else begin
         if (wr_acc & sel_mc)
            modem_control_q <= bus_req.writedata[4:0];
         if (wr_acc & sel_lc)
            line_control_q <= bus_req.writedata;
         if (wr_acc & sel_ie)
            int_enable_q <= bus_req.writedata[3:0];
         divisor_q <= divisor_d;
      end
   end

   // Status flags, change history and baud counter
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         changed_q    <= 4'h0;
         level_prev_q <= 4'h0;
         line_err_q   <= 4'h0;
         baud_count_q <= modem_ctrl_pkg::DIVISOR_RESET;
      end else begin
         changed_q    <= changed_d;
         level_prev_q <= level;
         line_err_q   <= line_err_d;
         baud_count_q <= baud_count_d;
      end
   end

   // Registered top-level outputs
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         terminal_ready_n <= 1'b1;
         request_send_n   <= 1'b1;
         serial_out       <= 1'b1;
         rx_shift_in      <= 1'b1;
         baud_tick        <= 1'b0;
         irq_out          <= 1'b0;
      end else begin
         terminal_ready_n <= tr_n_d;
         request_send_n   <= rs_n_d;
         serial_out       <= serial_out_d;
         rx_shift_in      <= rxin_d;
         baud_tick        <= tick_d;
         irq_out          <= irq_d;
      end
   end

   assign waitrequest = wait_q;
   assign readdata    = rdata_q;

endmodule : modem_ctrl

// ===== verif/modem_ctrl_properties.sv
module modem_ctrl_properties (
   input wire logic                      sys_clk,
   input wire logic                      rst_n,
   input wire modem_ctrl_pkg::avmm_req_t bus_req,
   input wire logic                      waitrequest,
   input wire logic [7:0]                readdata,
   input wire logic                      terminal_ready_n,
   input wire logic                      request_send_n,
   input wire logic                      serial_out,
   input wire logic                      irq_out
);
   logic [4:0] mc_q;
   // Accepted accesses, seen at the edge where waitrequest is low
   wire logic wr0 = bus_req.write & ~waitrequest & (bus_req.address == 5'h00);
   wire logic rd0 = bus_req.read & ~waitrequest & (bus_req.address == 5'h00);
   wire logic rd1 = bus_req.read & ~waitrequest & (bus_req.address == 5'h04);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Shadow of control bits; only accepted writes may move them
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n) mc_q <= 5'h00;
      else if (wr0) mc_q <= bus_req.writedata[4:0];
   a_wait_answer: assert property ((bus_req.read | bus_req.write) & waitrequest
      |=> !waitrequest) else $error("request not answered after one wait");
   a_wait_single: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_ready_follow: assert property (wr0 |-> ##2
      terminal_ready_n == ($past(bus_req.writedata[4], 2)
      | ~$past(bus_req.writedata[0], 2))) else $error("terminal ready wrong");
   a_rts_follow: assert property (wr0 |-> ##2
      request_send_n == ($past(bus_req.writedata[4], 2)
      | ~$past(bus_req.writedata[1], 2))) else $error("request send wrong");
   a_loop_serial: assert property (mc_q[4] && $past(mc_q[4]) |-> serial_out)
      else $error("serial output not high in loopback");
   a_irq_gate: assert property (!mc_q[3] && !$past(mc_q[3]) |-> !irq_out)
      else $error("interrupt seen while gated off");
   a_control_zero: assert property (rd0 |-> readdata == {3'h0, mc_q})
      else $error("control readback wrong");
   a_loop_status: assert property (rd1 && mc_q[4] && $past(mc_q, 3) == mc_q
      |-> readdata[7:4] == {mc_q[3], mc_q[2], mc_q[0], mc_q[1]})
      else $error("loopback status levels wrong");
   c_loop_read: cover property (rd1 && mc_q[4]);
   c_irq_rise: cover property ($rose(irq_out));
   c_loop_enter: cover property (wr0 && bus_req.writedata[4]);
endmodule : modem_ctrl_properties

bind modem_ctrl modem_ctrl_properties u_props (.sys_clk(sys_clk), .rst_n(rst_n),
   .bus_req(bus_req), .waitrequest(waitrequest), .readdata(readdata),
   .terminal_ready_n(terminal_ready_n), .request_send_n(request_send_n),
   .serial_out(serial_out), .irq_out(irq_out));

// ===== verif/modem_partner.sv
module modem_partner (
   input  wire logic [3:0]                lines,
   input  wire logic                      line_bit,
   output modem_ctrl_pkg::modem_in_t      modem_in,
   output logic                           serial_in
);
   // Lines are asserted high here; the pins themselves are active low
   assign modem_in  = ~lines;
   assign serial_in = line_bit;
endmodule : modem_partner

// ===== verif/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, rst_n, waitrequest, terminal_ready_n, request_send_n;
   logic serial_in, serial_out, tx_shift_out, rx_shift_in, baud_tick, irq_out;
   logic [7:0] readdata, v;
   logic [3:0] lines;
   logic       line_bit;
   int         errors, n_checks, n;
   modem_ctrl_pkg::avmm_req_t bus_req;
   modem_ctrl_pkg::modem_in_t modem_in;
   modem_ctrl_pkg::rx_err_t   rx_err;
   // Pin levels packed for one compare: rx, irq, serial out, rts, dtr
   wire logic [7:0] pins = {3'h0, rx_shift_in, irq_out, serial_out,
                            request_send_n, terminal_ready_n};
   // Lines to set and status expected after each change
   localparam logic [11:0] STEPS [6] = '{12'h111, 12'h332, 12'hBB8,
                                         12'hFF0, 12'hBB4, 12'hBB0};
   modem_ctrl u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req),
      .waitrequest(waitrequest), .readdata(readdata), .modem_in(modem_in),
      .terminal_ready_n(terminal_ready_n), .request_send_n(request_send_n),
      .serial_in(serial_in), .serial_out(serial_out),
      .tx_shift_out(tx_shift_out), .rx_shift_in(rx_shift_in), .rx_err(rx_err),
      .rx_data_ready(1'b0), .tx_holding_empty(1'b0), .tx_all_empty(1'b0),
      .baud_tick(baud_tick), .irq_out(irq_out));
   modem_partner u_modem (.lines(lines), .line_bit(line_bit),
      .modem_in(modem_in), .serial_in(serial_in));
   task chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One bus access; held until waitrequest is sampled low
   task acc(input logic w, input logic [2:0] i, input logic [7:0] d);
      @(posedge sys_clk);
      bus_req <= '{~w, w, {i, 2'b00}, d};
      do @(posedge sys_clk); while (waitrequest !== 1'b0);
      v = readdata;
      bus_req.read  <= 1'b0;
      bus_req.write <= 1'b0;
   endtask : acc
   task rc(input logic [2:0] i, input logic [7:0] exp, input string nm);
      acc(1'b0, i, 8'h00);
      chk(v, exp, nm);
   endtask : rc
   task cyc(input int k);
      repeat (k) @(posedge sys_clk);
   endtask : cyc
   task close_out;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // Watchdog; the whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge sys_clk);
      errors++;
      close_out();
   end
   initial begin
      rst_n = 1'b0; bus_req = '0; lines = 4'h0; line_bit = 1'b1;
      tx_shift_out = 1'b1; rx_err = '0;
      cyc(3);
      rst_n <= 1'b1;
      acc(1'b1, 3'h0, 8'hE3); cyc(3);
      chk(pins, 8'h14, "pins active");
      rc(3'h0, 8'h03, "control");
      acc(1'b0, 3'h1, 8'h00);
      for (int k = 0; k < 6; k++) begin
         lines <= STEPS[k][11:8]; cyc(6);
         rc(3'h1, STEPS[k][7:0], "status");
      end
      acc(1'b1, 3'h3, 8'h08); acc(1'b1, 3'h0, 8'h0B);
      lines <= 4'h0; cyc(6);
      chk(pins, 8'h1C, "modem irq");
      rc(3'h1, 8'h0B, "status"); cyc(3);
      chk(pins, 8'h14, "irq cleared");
      acc(1'b1, 3'h0, 8'h03); lines <= 4'h1; cyc(6);
      chk(pins, 8'h14, "irq gated");
      rc(3'h1, 8'h11, "status");
      // Line status is only read, never written
      acc(1'b1, 3'h3, 8'h04); acc(1'b1, 3'h0, 8'h0B);
      for (int i = 0; i < 4; i++) begin
         rx_err <= modem_ctrl_pkg::rx_err_t'(4'h1 << i); @(posedge sys_clk);
         rx_err <= '0; cyc(3);
         chk(pins, 8'h1C, "line irq");
         rc(3'h4, 8'h02 << i, "line status"); cyc(3);
         chk(pins, 8'h14, "line irq off");
      end
      acc(1'b1, 3'h0, 8'h1F); cyc(3);
      chk(pins, 8'h17, "loop pins");
      rc(3'h1, 8'hFA, "loop status"); lines <= 4'h0;
      acc(1'b1, 3'h0, 8'h1A); cyc(6);
      rc(3'h1, 8'h96, "loop status");
      tx_shift_out <= 1'b0; acc(1'b1, 3'h3, 8'h08);
      acc(1'b1, 3'h0, 8'h1F); cyc(3);
      chk(pins, 8'h0F, "loop irq");
      rc(3'h1, 8'hF2, "loop status"); acc(1'b1, 3'h0, 8'h00);
      // Out of loopback the pins carry data again; low levels prove the path
      line_bit <= 1'b0; cyc(4);
      chk(pins, 8'h03, "normal data path");
      // Both latches loaded before the rate is trusted
      acc(1'b1, 3'h2, 8'h80); acc(1'b1, 3'h5, 8'h03); acc(1'b1, 3'h6, 8'h00);
      rc(3'h5, 8'h03, "divisor"); acc(1'b1, 3'h2, 8'h00);
      rc(3'h5, 8'h00, "divisor hidden");
      repeat (2) begin
         n = 0;
         do begin @(posedge sys_clk); n++; end while (baud_tick !== 1'b1 && n < 50);
      end
      chk(8'(n), 8'h03, "baud period");
      close_out();
   end
endmodule : tb_top
